// ---- core/fsr_pkg.sv ----
// Constants for the floppy seek, recalibrate and interrupt block.
// Assumes a 200 MHz core clock; all ports synchronous to it.
package fsr_pkg;
  localparam int CLK_MHZ = 200;
  localparam int NUM_DRIVES = 4;
  localparam logic [7:0] RECAL_MAX_STEPS = 8'h4f;
  localparam int STEP_PULSE_NS = 1000;
  localparam int STEP_PULSE_CYC = (STEP_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int STEP_UNIT_US = 500;
  localparam int STEP_UNIT_CYC = STEP_UNIT_US * CLK_MHZ;
  localparam int FIRST_GAP_US = 250;
  localparam int FIRST_GAP_CYC = FIRST_GAP_US * CLK_MHZ;
  localparam logic [1:0] IC_NORMAL = 2'h0;
  localparam logic [1:0] IC_ABNORMAL = 2'h1;
  localparam logic [1:0] IC_POLL = 2'h3;
  localparam int ST0_DRV = 0;
  localparam int ST0_HEAD = 2;
  localparam int ST0_EC = 4;
  localparam int ST0_SE = 5;
  localparam int ST0_IC = 6;
  localparam logic [7:0] MFM_SYNC_LEN = 8'h0c;
  localparam logic [7:0] MFM_GAP1_LEN = 8'h32;
  localparam logic [7:0] MFM_GAP2_LEN = 8'h16;
  localparam logic [7:0] FM_GAP4A_LEN = 8'h28;
  localparam logic [7:0] FM_SYNC_LEN = 8'h06;
  localparam logic [7:0] FM_GAP1_LEN = 8'h1a;
  localparam logic [7:0] FM_GAP2_LEN = 8'h0b;
  localparam logic [7:0] MFM_GAP_BYTE = 8'h4e;
  localparam logic [7:0] FM_GAP_BYTE = 8'hff;
  localparam logic [7:0] SYNC_BYTE = 8'h00;
  typedef enum logic [2:0] {
    FSR_CMD_NONE, FSR_CMD_SEEK, FSR_CMD_RECAL, FSR_CMD_READID, FSR_CMD_SENSE, FSR_CMD_OTHER
  } fsr_cmd_t;
  typedef enum logic [3:0] {
    FMT_IDLE, FMT_GAP4A, FMT_SYNC0, FMT_IAM, FMT_GAP1, FMT_SYNC1, FMT_ID_ADDRESS_MARK, FMT_GAP2, FMT_SYNC2, FMT_DONE
  } fsr_fmt_t;
endpackage

// ---- core/fsr_step_gen.sv ----
// Step pulse generator for one positioning engine.
// Assumes an interval code from Specify; 0 gives the longest interval.
`timescale 1ns/10ps
module fsr_step_gen
  import fsr_pkg::*;
#(
  parameter int UNIT_CYC = STEP_UNIT_CYC,
  parameter int FIRST_CYC = FIRST_GAP_CYC
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic run,
  input wire logic [3:0] step_interval_code,
  output logic step_out,
  output logic step_done
);
  logic [31:0] cnt_q;
  logic first_q;
  logic [31:0] interval;
  logic [4:0] units;
  assign units = 5'h10 - {1'b0, step_interval_code};
  // First gap may be shorter than the rest
  assign interval = first_q ? 32'(FIRST_CYC) : 32'(UNIT_CYC) * {27'h0, units};
  always_ff @(posedge core_clk) begin
    if (srst || !run) begin
      cnt_q <= 32'h0;
      first_q <= 1'b1;
    end else if (cnt_q + 32'h1 >= interval) begin
      cnt_q <= 32'h0;
      first_q <= 1'b0;
    end else begin
      cnt_q <= cnt_q + 32'h1;
    end
  end
  // Low in the last cycle so a short first gap never merges two pulses
  assign step_out = run && (cnt_q < 32'(STEP_PULSE_CYC)) && !step_done;
  assign step_done = run && (cnt_q + 32'h1 >= interval);
endmodule

// ---- core/fsr_fmt_seq.sv ----
// Preamble byte sequencer for track formatting (gaps and sync runs).
// Assumes the caller takes one byte per byte_take pulse; marks come from elsewhere.
`timescale 1ns/10ps
module fsr_fmt_seq
  import fsr_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic start,
  input wire logic mfm,
  input wire logic byte_take,
  output logic [7:0] fmt_byte,
  output logic fmt_is_mark,
  output logic fmt_busy
);
  fsr_fmt_t st_q;
  fsr_fmt_t st_d;
  logic [7:0] cnt_q;
  logic [7:0] len;
  logic [7:0] gapb;
  assign gapb = mfm ? MFM_GAP_BYTE : FM_GAP_BYTE;
  always_comb begin
    case (st_q)
      FMT_GAP4A: len = FM_GAP4A_LEN;
      FMT_SYNC0, FMT_SYNC1, FMT_SYNC2: len = mfm ? MFM_SYNC_LEN : FM_SYNC_LEN;
      FMT_GAP1: len = mfm ? MFM_GAP1_LEN : FM_GAP1_LEN;
      FMT_GAP2: len = mfm ? MFM_GAP2_LEN : FM_GAP2_LEN;
      default: len = 8'h1;
    endcase
  end
  always_comb begin
    case (st_q)
      FMT_IDLE: st_d = start ? (mfm ? FMT_SYNC0 : FMT_GAP4A) : FMT_IDLE;
      FMT_GAP4A: st_d = FMT_SYNC0;
      FMT_SYNC0: st_d = FMT_IAM;
      FMT_IAM: st_d = FMT_GAP1;
      FMT_GAP1: st_d = FMT_SYNC1;
      FMT_SYNC1: st_d = FMT_ID_ADDRESS_MARK;
      FMT_ID_ADDRESS_MARK: st_d = FMT_GAP2;
      FMT_GAP2: st_d = FMT_SYNC2;
      FMT_SYNC2: st_d = FMT_DONE;
      default: st_d = FMT_IDLE;
    endcase
  end
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_q <= FMT_IDLE;
      cnt_q <= 8'h0;
    end else if (st_q == FMT_IDLE || st_q == FMT_DONE) begin
      st_q <= st_d;
      cnt_q <= 8'h0;
    end else if (byte_take) begin
      if (cnt_q + 8'h1 >= len) begin
        st_q <= st_d;
        cnt_q <= 8'h0;
      end else begin
        cnt_q <= cnt_q + 8'h1;
      end
    end
  end
  assign fmt_is_mark = (st_q == FMT_IAM) || (st_q == FMT_ID_ADDRESS_MARK);
  assign fmt_byte = (st_q == FMT_SYNC0 || st_q == FMT_SYNC1 || st_q == FMT_SYNC2) ? SYNC_BYTE : gapb;
  // Done state offers no byte
  assign fmt_busy = (st_q != FMT_IDLE) && (st_q != FMT_DONE);
endmodule

// ---- core/fsr_ctl.sv ----
// Seek, recalibrate, read-id and interrupt reporting for up to four drives.
// Assumes one command strobe per cycle with decoded command and drive fields.
`timescale 1ns/10ps
module fsr_ctl
  import fsr_pkg::*;
#(
  parameter int UNIT_CYC = STEP_UNIT_CYC,
  parameter int FIRST_CYC = FIRST_GAP_CYC
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic cmd_valid,
  input wire fsr_cmd_t cmd_code,
  input wire logic [1:0] cmd_drive,
  input wire logic [7:0] target_cylinder_value,
  input wire logic [3:0] step_interval_code,
  input wire logic non_dma_select,
  input wire logic xfer_needed,
  input wire logic result_phase_entry,
  input wire logic poll_event,
  input wire logic powerdown_exit,
  input wire logic track_zero_input,
  input wire logic index_pulse_input,
  input wire logic id_found,
  input wire logic [7:0] id_cyl,
  input wire logic [7:0] id_head,
  input wire logic [7:0] id_sec,
  input wire logic [7:0] id_size,
  input wire logic fmt_start,
  input wire logic fmt_mfm,
  input wire logic fmt_byte_take,
  output logic cmd_ready,
  output logic [3:0] drive_busy,
  output logic [3:0] step_pulse,
  output logic [3:0] step_dir,
  output logic controller_irq,
  output logic request_for_master,
  output logic dma_request_pin,
  output logic [7:0] status_zero,
  output logic [7:0] sense_cylinder,
  output logic sense_valid,
  output logic missing_mark_flag,
  output logic [7:0] rid_cyl_q,
  output logic [7:0] rid_head_q,
  output logic [7:0] rid_sec_q,
  output logic [7:0] rid_size_q,
  output logic readid_busy,
  output logic [7:0] fmt_byte,
  output logic fmt_is_mark,
  output logic fmt_busy
);
  // Per-drive engine state
  logic [7:0] pcn_q [NUM_DRIVES];
  logic [7:0] ncn_q [NUM_DRIVES];
  logic [3:0] seek_run_q;
  logic [3:0] recal_run_q;
  logic [3:0] dir_q;
  logic [7:0] recal_cnt_q [NUM_DRIVES];
  logic [3:0] pend_q;
  logic [1:0] pend_ic_q [NUM_DRIVES];
  logic [3:0] pend_se_q;
  logic [3:0] pend_ec_q;
  logic [3:0] step_done;
  logic [3:0] run;
  // Read ID state
  logic rid_run_q;
  logic [1:0] rid_drv_q;
  logic [1:0] idx_cnt_q;
  logic idx_prev_q;
  logic rid_pend_q;
  logic [1:0] rid_ic_q;
  logic poll_pend_q;
  logic irq_xfer;
  logic idx_rise;
  logic sense_cmd;
  logic [1:0] sense_drv;
  logic sense_any_pos;
  logic [7:0] st0_d;

  function automatic logic [1:0] first_set(input logic [3:0] v);
    logic [1:0] r;
    r = 2'h0;
    for (int i = NUM_DRIVES - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 2'(i);
      end
    end
    return r;
  endfunction

  function automatic logic [7:0] make_st0(input logic [1:0] ic, input logic se, input logic ec,
                                          input logic [1:0] drv);
    logic [7:0] s;
    s = 8'h0;
    s[ST0_IC +: 2] = ic;
    s[ST0_SE] = se;
    s[ST0_EC] = ec;
    s[ST0_HEAD] = 1'b0;
    s[ST0_DRV +: 2] = drv;
    return s;
  endfunction

  assign run = seek_run_q | recal_run_q;

  for (genvar g = 0; g < NUM_DRIVES; g++) begin : g_step
    fsr_step_gen #(
      .UNIT_CYC(UNIT_CYC),
      .FIRST_CYC(FIRST_CYC)
    ) u_step (
      .core_clk(core_clk),
      .srst(srst),
      .run(run[g]),
      .step_interval_code(step_interval_code),
      .step_out(step_pulse[g]),
      .step_done(step_done[g])
    );
  end

  fsr_fmt_seq u_fmt (
    .core_clk(core_clk),
    .srst(srst),
    .start(fmt_start),
    .mfm(fmt_mfm),
    .byte_take(fmt_byte_take),
    .fmt_byte(fmt_byte),
    .fmt_is_mark(fmt_is_mark),
    .fmt_busy(fmt_busy)
  );

  // Command taken in one cycle, so busy never spans execution
  assign cmd_ready = 1'b1;
  assign drive_busy = run | pend_q;
  assign step_dir = dir_q;
  assign readid_busy = rid_run_q;
  assign idx_rise = index_pulse_input && !idx_prev_q;
  assign sense_cmd = cmd_valid && (cmd_code == FSR_CMD_SENSE);
  assign sense_any_pos = |pend_q;
  assign sense_drv = first_set(pend_q);
  assign irq_xfer = non_dma_select && xfer_needed;
  assign request_for_master = irq_xfer;
  assign dma_request_pin = !non_dma_select && xfer_needed;
  // Positioning ends, read id, result phase, poll events and non-DMA transfer requests raise the line
  assign controller_irq = sense_any_pos | rid_pend_q | poll_pend_q | irq_xfer;

  always_comb begin
    if (sense_any_pos) begin
      st0_d = make_st0(pend_ic_q[sense_drv], pend_se_q[sense_drv], pend_ec_q[sense_drv], sense_drv);
    end else if (rid_pend_q) begin
      st0_d = make_st0(rid_ic_q, 1'b0, 1'b0, rid_drv_q);
    end else if (poll_pend_q) begin
      st0_d = make_st0(IC_POLL, 1'b0, 1'b0, 2'h0);
    end else begin
      st0_d = make_st0(IC_POLL, 1'b0, 1'b0, 2'h0);
    end
  end

  for (genvar g = 0; g < NUM_DRIVES; g++) begin : g_drv
    logic start_seek;
    logic start_recal;
    logic sensed;
    logic [7:0] nxt;
    assign start_seek = cmd_valid && cmd_code == FSR_CMD_SEEK && cmd_drive == 2'(g);
    assign start_recal = cmd_valid && cmd_code == FSR_CMD_RECAL && cmd_drive == 2'(g);
    assign sensed = sense_cmd && sense_any_pos && sense_drv == 2'(g);
    assign nxt = dir_q[g] ? pcn_q[g] + 8'h1 : pcn_q[g] - 8'h1;
    always_ff @(posedge core_clk) begin
      if (srst || powerdown_exit) begin
        pcn_q[g] <= 8'h0;
        ncn_q[g] <= 8'h0;
        seek_run_q[g] <= 1'b0;
        recal_run_q[g] <= 1'b0;
        dir_q[g] <= 1'b0;
        recal_cnt_q[g] <= 8'h0;
        pend_q[g] <= 1'b0;
        pend_ic_q[g] <= IC_NORMAL;
        pend_se_q[g] <= 1'b0;
        pend_ec_q[g] <= 1'b0;
      end else if (start_recal) begin
        pcn_q[g] <= 8'h0;
        dir_q[g] <= 1'b0;
        recal_cnt_q[g] <= 8'h0;
        recal_run_q[g] <= !track_zero_input;
        seek_run_q[g] <= 1'b0;
        pend_q[g] <= track_zero_input;
        pend_se_q[g] <= 1'b1;
        pend_ec_q[g] <= 1'b0;
        pend_ic_q[g] <= IC_NORMAL;
      end else if (start_seek) begin
        ncn_q[g] <= target_cylinder_value;
        dir_q[g] <= pcn_q[g] < target_cylinder_value;
        seek_run_q[g] <= pcn_q[g] != target_cylinder_value;
        recal_run_q[g] <= 1'b0;
        pend_q[g] <= pcn_q[g] == target_cylinder_value;
        pend_se_q[g] <= 1'b1;
        pend_ec_q[g] <= 1'b0;
        pend_ic_q[g] <= IC_NORMAL;
      end else begin
        if (recal_run_q[g]) begin
          if (track_zero_input) begin
            recal_run_q[g] <= 1'b0;
            pend_q[g] <= 1'b1;
            pend_se_q[g] <= 1'b1;
            pend_ic_q[g] <= IC_NORMAL;
          end else if (step_done[g]) begin
            if (recal_cnt_q[g] + 8'h1 >= RECAL_MAX_STEPS) begin
              recal_run_q[g] <= 1'b0;
              pend_q[g] <= 1'b1;
              pend_se_q[g] <= 1'b1;
              pend_ec_q[g] <= 1'b1;
              pend_ic_q[g] <= IC_ABNORMAL;
            end
            recal_cnt_q[g] <= recal_cnt_q[g] + 8'h1;
          end
        end else if (seek_run_q[g] && step_done[g]) begin
          pcn_q[g] <= nxt;
          if (nxt == ncn_q[g]) begin
            seek_run_q[g] <= 1'b0;
            pend_q[g] <= 1'b1;
            pend_se_q[g] <= 1'b1;
            pend_ic_q[g] <= IC_NORMAL;
          end
        end else if (sensed) begin
          pend_q[g] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst || powerdown_exit) begin
      rid_run_q <= 1'b0;
      rid_drv_q <= 2'h0;
      idx_cnt_q <= 2'h0;
      idx_prev_q <= 1'b0;
      rid_pend_q <= 1'b0;
      rid_ic_q <= IC_NORMAL;
      missing_mark_flag <= 1'b0;
      rid_cyl_q <= 8'h0;
      rid_head_q <= 8'h0;
      rid_sec_q <= 8'h0;
      rid_size_q <= 8'h0;
      poll_pend_q <= 1'b0;
      status_zero <= 8'h0;
      sense_cylinder <= 8'h0;
      sense_valid <= 1'b0;
    end else begin
      idx_prev_q <= index_pulse_input;
      sense_valid <= sense_cmd;
      if (poll_event) begin
        poll_pend_q <= 1'b1;
      end else if (sense_cmd && !sense_any_pos && !rid_pend_q) begin
        poll_pend_q <= 1'b0;
      end
      if (sense_cmd) begin
        status_zero <= st0_d;
        sense_cylinder <= sense_any_pos ? pcn_q[sense_drv] : 8'h0;
      end
      if (cmd_valid && cmd_code == FSR_CMD_READID) begin
        rid_run_q <= 1'b1;
        rid_drv_q <= cmd_drive;
        idx_cnt_q <= 2'h0;
        missing_mark_flag <= 1'b0;
      end else if (rid_run_q) begin
        if (id_found) begin
          rid_cyl_q <= id_cyl;
          rid_head_q <= id_head;
          rid_sec_q <= id_sec;
          rid_size_q <= id_size;
          rid_run_q <= 1'b0;
          rid_pend_q <= 1'b1;
          rid_ic_q <= IC_NORMAL;
        end else if (idx_rise) begin
          if (idx_cnt_q == 2'h1) begin
            rid_run_q <= 1'b0;
            rid_pend_q <= 1'b1;
            rid_ic_q <= IC_ABNORMAL;
            missing_mark_flag <= 1'b1;
          end
          idx_cnt_q <= idx_cnt_q + 2'h1;
        end
      end else if (result_phase_entry) begin
        rid_pend_q <= 1'b1;
      end else if (sense_cmd && !sense_any_pos) begin
        rid_pend_q <= 1'b0;
      end
    end
  end
endmodule

// ---- tb/fsr_drive_model.sv ----
// Behavioural drive mechanism: head position per drive, track-zero and index.
// Assumes step pulses and direction from the controller on the core clock.
`timescale 1ns/10ps
module fsr_drive_model (
  input wire logic core_clk,
  input wire logic [3:0] step_pulse,
  input wire logic [3:0] step_dir,
  input wire logic [1:0] sel,
  input wire logic spin,
  output logic track_zero_input,
  output logic index_pulse_input
);
  // Drive 2 sits beyond reach of one recalibrate
  int pos [4] = '{0, 5, 90, 0};
  logic [3:0] prev = 4'h0;
  int tick = 0;
  always @(posedge core_clk) begin
    prev <= step_pulse;
    tick <= spin ? tick + 1 : 0;
    for (int i = 0; i < 4; i++)
      if (step_pulse[i] && !prev[i])
        pos[i] <= step_dir[i] ? pos[i] + 1 : (pos[i] > 0 ? pos[i] - 1 : 0);
  end
  assign track_zero_input = (pos[sel] == 0);
  assign index_pulse_input = spin && tick[5];
endmodule

// ---- tb/fsr_ctl_checker.sv ----
// Port-level assertions for the seek, recalibrate and interrupt block.
// Assumes binding onto fsr_ctl; one clock domain.
`timescale 1ns/10ps
module fsr_ctl_checker
  import fsr_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic cmd_valid,
  input wire fsr_cmd_t cmd_code,
  input wire logic [1:0] cmd_drive,
  input wire logic powerdown_exit,
  input wire logic id_found,
  input wire logic [7:0] id_cyl,
  input wire logic [3:0] drive_busy,
  input wire logic [3:0] step_pulse,
  input wire logic [3:0] step_dir,
  input wire logic [7:0] status_zero,
  input wire logic sense_valid,
  input wire logic missing_mark_flag,
  input wire logic [7:0] rid_cyl_q,
  input wire logic readid_busy
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  logic pos_cmd;
  assign pos_cmd = cmd_valid && (cmd_code == FSR_CMD_SEEK || cmd_code == FSR_CMD_RECAL);
  AST_POS_BUSY: assert property (pos_cmd |=> drive_busy[$past(cmd_drive)])
    else $error("drive not busy after positioning command");
  AST_RECAL_DIR: assert property (cmd_valid && cmd_code == FSR_CMD_RECAL |=> !step_dir[$past(cmd_drive)])
    else $error("recalibrate direction not outward");
  AST_SENSE_VALID: assert property (cmd_valid && cmd_code == FSR_CMD_SENSE |=> sense_valid)
    else $error("sense answer missing");
  AST_HEAD_ZERO: assert property (sense_valid |-> !status_zero[ST0_HEAD])
    else $error("head bit set in status");
  AST_EC_CODE: assert property (sense_valid && status_zero[ST0_EC]
      |-> status_zero[ST0_SE] && status_zero[ST0_IC+:2] == IC_ABNORMAL)
    else $error("equipment check without abnormal seek end");
  AST_PULSE_HOLD: assert property ($rose(step_pulse[0]) |-> step_pulse[0] [*8])
    else $error("step pulse too short");
  AST_RID_LATCH: assert property (id_found && readid_busy |=> rid_cyl_q == $past(id_cyl))
    else $error("read id cylinder not latched");
  AST_PWR_CLR: assert property (powerdown_exit |=> status_zero == 8'h00)
    else $error("status not cleared on wake");
  AST_STEP_IDLE: assert property (!drive_busy[1] |-> !step_pulse[1])
    else $error("step pulse on idle drive");
  COV_EC: cover property (sense_valid && status_zero[ST0_EC]);
  COV_SE: cover property (sense_valid && status_zero[ST0_SE]);
  COV_MA: cover property ($rose(missing_mark_flag));
endmodule
bind fsr_ctl fsr_ctl_checker chk_u (.core_clk(core_clk), .srst(srst), .cmd_valid(cmd_valid),
  .cmd_code(cmd_code), .cmd_drive(cmd_drive), .powerdown_exit(powerdown_exit), .id_found(id_found),
  .id_cyl(id_cyl), .drive_busy(drive_busy), .step_pulse(step_pulse), .step_dir(step_dir),
  .status_zero(status_zero), .sense_valid(sense_valid), .missing_mark_flag(missing_mark_flag),
  .rid_cyl_q(rid_cyl_q), .readid_busy(readid_busy));

// ---- tb/test_fsr_ctl.sv ----
// Self-checking bench for fsr_ctl with a drive model on the far side.
// Assumes shortened step timing (UNIT_CYC 20, FIRST_CYC 10).
`timescale 1ns/10ps
module test_fsr_ctl
  import fsr_pkg::*;
;
  logic core_clk = 0, srst = 1, cmd_valid = 0, non_dma_select = 0, xfer_needed = 0;
  logic result_phase_entry = 0, poll_event = 0, powerdown_exit = 0, id_found = 0;
  logic fmt_start = 0, fmt_mfm = 0, fmt_byte_take = 0, spin = 0;
  fsr_cmd_t cmd_code = FSR_CMD_NONE;
  logic [1:0] cmd_drive = 2'h0, sel = 2'h0;
  logic [7:0] target_cylinder_value = 8'h00, id_cyl = 8'h00;
  logic [7:0] id_head = 8'h00, id_sec = 8'h00, id_size = 8'h00, rid_head_q, rid_sec_q, rid_size_q;
  logic [3:0] step_interval_code = 4'h0;
  int cyc = 0, gap = 0, last_up = 0;
  logic [3:0] drive_busy, step_pulse, step_dir;
  logic [7:0] status_zero, sense_cylinder, rid_cyl_q, fmt_byte;
  logic cmd_ready, controller_irq, request_for_master, dma_request_pin, sense_valid;
  logic missing_mark_flag, readid_busy, fmt_is_mark, fmt_busy, track_zero_input, index_pulse_input;
  int failures = 0, n_tests = 0;
  int rises [4];
  logic [3:0] sp_q = 4'h0;
  fsr_ctl #(.UNIT_CYC(20), .FIRST_CYC(10)) dut_u (.core_clk(core_clk), .srst(srst), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_drive(cmd_drive), .target_cylinder_value(target_cylinder_value),
    .step_interval_code(step_interval_code), .non_dma_select(non_dma_select), .xfer_needed(xfer_needed),
    .result_phase_entry(result_phase_entry), .poll_event(poll_event), .powerdown_exit(powerdown_exit),
    .track_zero_input(track_zero_input), .index_pulse_input(index_pulse_input), .id_found(id_found),
    .id_cyl(id_cyl), .id_head(id_head), .id_sec(id_sec), .id_size(id_size), .fmt_start(fmt_start),
    .fmt_mfm(fmt_mfm), .fmt_byte_take(fmt_byte_take), .cmd_ready(cmd_ready), .drive_busy(drive_busy),
    .step_pulse(step_pulse), .step_dir(step_dir), .controller_irq(controller_irq),
    .request_for_master(request_for_master), .dma_request_pin(dma_request_pin),
    .status_zero(status_zero), .sense_cylinder(sense_cylinder), .sense_valid(sense_valid),
    .missing_mark_flag(missing_mark_flag), .rid_cyl_q(rid_cyl_q), .rid_head_q(rid_head_q),
    .rid_sec_q(rid_sec_q), .rid_size_q(rid_size_q), .readid_busy(readid_busy), .fmt_byte(fmt_byte),
    .fmt_is_mark(fmt_is_mark),
    .fmt_busy(fmt_busy));
  fsr_drive_model drv_u (.core_clk(core_clk), .step_pulse(step_pulse), .step_dir(step_dir), .sel(sel),
    .spin(spin), .track_zero_input(track_zero_input), .index_pulse_input(index_pulse_input));
  initial begin
    forever #2.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    sp_q <= step_pulse;
    cyc <= cyc + 1;
    // Cycles between the last two step pulses of drive 0
    if (step_pulse[0] && !sp_q[0]) begin
      gap <= cyc - last_up;
      last_up <= cyc;
    end
    for (int i = 0; i < 4; i++)
      if (step_pulse[i] && !sp_q[i]) rises[i]++;
  end
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmd(input fsr_cmd_t c, input logic [1:0] d, input logic [7:0] t);
    @(negedge core_clk);
    cmd_valid = 1;
    cmd_code = c;
    cmd_drive = d;
    target_cylinder_value = t;
    @(negedge core_clk);
    cmd_valid = 0;
  endtask
  task automatic wait_irq();
    int n;
    for (n = 0; n < 40000 && controller_irq !== 1'b1; n++)
      @(negedge core_clk);
    if (n == 40000) begin
      failures++;
      results();
    end
  endtask
  task automatic pos_run(input fsr_cmd_t c, input logic [1:0] d, input logic [7:0] t, input int steps,
                         input logic [7:0] st);
    sel = d;
    rises = '{0, 0, 0, 0};
    cmd(c, d, t);
    wait_irq();
    chk(8'(rises[d]), 8'(steps));
    chk({7'h0, drive_busy[d]}, 8'h01);
    cmd(FSR_CMD_SENSE, 2'h0, 8'h00);
    chk(status_zero, st);
    chk({7'h0, drive_busy[d]}, 8'h00);
  endtask
  task automatic t_position();
    pos_run(FSR_CMD_RECAL, 2'h1, 8'h00, 5, 8'h21);
    chk(sense_cylinder, 8'h00);
    pos_run(FSR_CMD_RECAL, 2'h2, 8'h00, 79, 8'h72);
    pos_run(FSR_CMD_SEEK, 2'h0, 8'h03, 3, 8'h20);
    chk({7'h0, step_dir[0]}, 8'h01);
    chk(sense_cylinder, 8'h03);
    chk(8'(gap / 4), 8'h50);
    pos_run(FSR_CMD_SEEK, 2'h0, 8'h01, 2, 8'h20);
    chk({7'h0, step_dir[0]}, 8'h00);
    chk(8'(gap), 8'h0a);
    $display("positioning test done");
  endtask
  task automatic t_overlap();
    sel = 2'h0;
    cmd(FSR_CMD_SEEK, 2'h3, 8'h02);
    cmd(FSR_CMD_SEEK, 2'h0, 8'h02);
    chk({4'h0, drive_busy}, 8'h09);
    wait_irq();
    cmd(FSR_CMD_SENSE, 2'h0, 8'h00);
    chk(status_zero, 8'h20);
    wait_irq();
    repeat (800) @(negedge core_clk);
    cmd(FSR_CMD_SENSE, 2'h0, 8'h00);
    chk(status_zero, 8'h23);
    chk(sense_cylinder, 8'h02);
    $display("overlap test done");
  endtask
  task automatic t_readid();
    spin = 1;
    cmd(FSR_CMD_READID, 2'h0, 8'h00);
    id_cyl = 8'h02;
    id_head = 8'h01;
    id_sec = 8'h09;
    id_size = 8'h02;
    id_found = 1;
    @(negedge core_clk);
    id_cyl = 8'h07;
    @(negedge core_clk);
    id_found = 0;
    chk(rid_cyl_q, 8'h02);
    chk(rid_head_q, 8'h01);
    chk(rid_sec_q, 8'h09);
    chk(rid_size_q, 8'h02);
    wait_irq();
    cmd(FSR_CMD_SENSE, 2'h0, 8'h00);
    cmd(FSR_CMD_READID, 2'h0, 8'h00);
    wait_irq();
    chk({7'h0, missing_mark_flag}, 8'h01);
    cmd(FSR_CMD_SENSE, 2'h0, 8'h00);
    chk({6'h0, status_zero[ST0_IC+:2]}, {6'h0, IC_ABNORMAL});
    spin = 0;
    $display("read id test done");
  endtask
  task automatic t_irq();
    cmd(FSR_CMD_OTHER, 2'h0, 8'h00);
    repeat (50) @(negedge core_clk);
    chk({7'h0, controller_irq}, 8'h00);
    poll_event = 1;
    @(negedge core_clk);
    poll_event = 0;
    wait_irq();
    cmd(FSR_CMD_SENSE, 2'h0, 8'h00);
    chk({5'h0, status_zero[7:5]}, 8'h06);
    non_dma_select = 1;
    xfer_needed = 1;
    @(negedge core_clk);
    chk({6'h0, controller_irq, request_for_master}, 8'h03);
    non_dma_select = 0;
    @(negedge core_clk);
    chk({7'h0, dma_request_pin}, 8'h01);
    xfer_needed = 0;
    powerdown_exit = 1;
    @(negedge core_clk);
    powerdown_exit = 0;
    step_interval_code = 4'he;
    pos_run(FSR_CMD_SEEK, 2'h0, 8'h03, 3, 8'h20);
    chk(8'(gap), 8'h28);
    result_phase_entry = 1;
    @(negedge core_clk);
    result_phase_entry = 0;
    chk({7'h0, controller_irq}, 8'h01);
    srst = 1;
    repeat (20) @(negedge core_clk);
    srst = 0;
    chk({6'h0, controller_irq, cmd_ready}, 8'h01);
    $display("interrupt test done");
  endtask
  task automatic t_fmt(input logic m, input logic [15:0] exp [$]);
    logic [15:0] q [$];
    // Let a finished run fall back to idle first
    @(negedge core_clk);
    fmt_mfm = m;
    fmt_start = 1;
    @(negedge core_clk);
    fmt_start = 0;
    for (int n = 0; n < 400 && fmt_busy === 1'b1; n++) begin
      if (!fmt_is_mark && q.size() > 0 && q[$][15:8] === fmt_byte) q[$] = q[$] + 16'h1;
      else if (!fmt_is_mark) q.push_back({fmt_byte, 8'h01});
      fmt_byte_take = 1;
      @(negedge core_clk);
      fmt_byte_take = 0;
      @(negedge core_clk);
    end
    if (fmt_busy === 1'b1) begin
      failures++;
      results();
    end
    chk(8'(q.size()), 8'(exp.size()));
    foreach (exp[i]) chk(q[i][7:0], exp[i][7:0]);
    foreach (exp[i]) chk(q[i][15:8], exp[i][15:8]);
    $display("format test done");
  endtask
  initial begin
    repeat (20) @(negedge core_clk);
    srst = 0;
    chk(fmt_byte, 8'hff);
    t_position();
    t_overlap();
    t_readid();
    t_fmt(1'b1, '{16'h000c, 16'h4e32, 16'h000c, 16'h4e16, 16'h000c});
    t_fmt(1'b0, '{16'hff28, 16'h0006, 16'hff1a, 16'h0006, 16'hff0b, 16'h0006});
    t_irq();
    results();
  end
endmodule
